// file: rtl/mic_map.vh
// Register map, field positions and vectors of the interrupt control block
`ifndef MIC_MAP_VH
`define MIC_MAP_VH

// ==========================================================
// Register offsets (byte addresses)
`define MIC_OFF_MASK     5'h00
`define MIC_OFF_CTRL     5'h04
`define MIC_OFF_STAT     5'h08
`define MIC_OFF_EVENT    5'h0c
`define MIC_OFF_ACCEPT   5'h10

// ==========================================================
// Field positions
`define MIC_MASK_ES      5
`define MIC_PSW_L0       2
`define MIC_PSW_L1       3
`define MIC_STAT_IE      8
`define MIC_STAT_SOFT    9
`define MIC_STAT_L0      10
`define MIC_STAT_L1      11
`define MIC_STAT_ACT     12
`define MIC_EV_EI        0
`define MIC_EV_DI        1
`define MIC_EV_SOFTWARE_IRQ_INSTR     2
`define MIC_EV_RETURN_FROM_IRQ_INSTR      3
`define MIC_EV_TIMER     4
`define MIC_EV_SERIAL    5

// ==========================================================
// Reset values
`define MIC_MASK_RST     8'h00
`define MIC_PSW_RST      8'h00

// ==========================================================
// Vectors
`define MIC_VEC_LEVEL    16'h0004
`define MIC_VEC_TIMER    16'h0008
`define MIC_VEC_RISE     16'h0010
`define MIC_VEC_SEL      16'h0020
`define MIC_VEC_SERIAL   16'h0040
`define MIC_VEC_SOFT     16'h0060

`endif

// file: rtl/mic_prio.v
// Fixed priority resolver with vector lookup
`timescale 1ns/10ps
`include "mic_map.vh"

module mic_prio (
   // Qualified requests: 0 level, 1 timer, 2 rise, 3 selectable, 4 serial
   input wire [4:0] req,
   // Winner
   output reg [4:0] grant,
   output reg [15:0] vector
);

   always @* begin
      grant = 5'h00;
      vector = 16'h0000;
      if (req[0]) begin //R1
         grant = 5'h01;
         vector = `MIC_VEC_LEVEL; //R9
      end else if (req[1]) begin
         grant = 5'h02;
         vector = `MIC_VEC_TIMER;
      end else if (req[2]) begin
         grant = 5'h04;
         vector = `MIC_VEC_RISE;
      end else if (req[3]) begin
         grant = 5'h08;
         vector = `MIC_VEC_SEL;
      end else if (req[4]) begin
         grant = 5'h10;
         vector = `MIC_VEC_SERIAL;
      end
   end

endmodule

// file: rtl/mic_ctrl.v
// Interrupt control block: request flags, mask, enable, soft request, chain flags
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "mic_map.vh"

// How it works
// R1 - Highest of level, timer, rise, selectable, serial wins when several pend.
// R2 - Enable instruction sets enable flip-flop; disable instruction clears it.
// R3 - Hardware requests taken only while enabled; otherwise they stay pending.
// R4 - Reset clears the enable flip-flop.
// R5 - Software interrupt sets soft request, blocking all five hardware requests.
// R6 - Return instruction clears soft request and lifts the block.
// R7 - Accepting a hardware interrupt clears the enable flip-flop.
// R8 - Acceptance pushes status word and program counter.
// R9 - Vectors 4, 8, 16, 32, 64 per source.
// R10 - Acceptance clears the accepted source's request flag, except the level flag, which follows its input.
// R11 - Software interrupt pushes state then branches to 96.
// R12 - Software interrupt taken whether enabled or not.
// R13 - Request flags readable for test without taking the interrupt.
// R14 - In a chain of immediate loads only the first executes.
// R15 - Chaining works only within group A or within group B.
// R16 - Chained A sets accumulator flag, chained B pair flag; others clear both.
// R17 - Interrupts not held off in chains; chain flags saved with status.
// R18 - Mask bit 5 selects edge of the selectable input.
// R19 - Edge select one means rising, zero means falling.
// R20 - Level flag follows its input.
// R21 - Rise flag set on each rising edge.
// R22 - Timer flag set on each timer overflow.
// R23 - Mask bit blocks its source without clearing its flag.
// R24 - Return restores program counter and status, reviving chain flags. Of the status, only chain flags are used; psw_base_q drives nothing.
module mic_ctrl (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // External request pins
   input wire ext_level_request,
   input wire ext_rise_request,
   input wire ext_selectable_edge_request,
   // Core instruction strobes, one cycle each; irq_ack is a level the core holds
   input wire enable_irq_instr,
   input wire disable_irq_instr,
   input wire software_irq_instr,
   input wire return_from_irq_instr,
   input wire immediate_load_instr,
   input wire acc_load_instr,
   input wire pair_immediate_load_instr,
   input wire other_instr,
   input wire irq_ack,
   // Internal request sources, one-cycle pulses
   input wire timer_request,
   input wire serial_request,
   // Core state and return path
   input wire [15:0] program_counter,
   input wire [7:0] psw_alu_flags,
   input wire [15:0] restore_pc,
   input wire [7:0] restore_psw,
   // Acceptance to core
   output wire irq_pending,
   output reg accept_q,
   output reg [15:0] vector_q,
   output reg [15:0] saved_pc_q,
   output reg [7:0] saved_psw_q,
   output reg [15:0] resume_pc_q,
   output wire [7:0] program_status_word,
   output wire exec_suppress,
   output wire [4:0] request_flags
);

   // ==========================================================
   // Synchronisers for the pins
   reg [2:0] pin_s1_q;
   reg [2:0] pin_s2_q;
   reg [2:0] pin_prev_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
         pin_prev_q <= 3'h0;
      end else begin
         pin_s1_q <= {ext_selectable_edge_request, ext_rise_request, ext_level_request};
         pin_s2_q <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // ==========================================================
   // Register state
   reg [7:0] mask_q;
   reg ie_q;
   reg soft_request_ff_q;
   reg level_request_flag_q;
   reg rise_request_flag_q;
   reg sel_request_flag_q;
   reg timer_request_flag_q;
   reg serial_request_flag_q;
   reg acc_chain_flag_q;
   reg pair_chain_flag_q;
   reg [7:0] psw_base_q;
   reg [5:0] sw_event_q;

   wire es = mask_q[`MIC_MASK_ES];
   wire rise_edge = pin_s2_q[1] & ~pin_prev_q[1];
   // R19: rising when set, falling when clear
   wire sel_edge = es ? (pin_s2_q[2] & ~pin_prev_q[2]) : (~pin_s2_q[2] & pin_prev_q[2]); //R18

   // Events arrive either from the core and internal sources or from the event register
   wire ev_ei = enable_irq_instr | sw_event_q[`MIC_EV_EI];
   wire ev_di = disable_irq_instr | sw_event_q[`MIC_EV_DI];
   wire ev_software_irq_instr = software_irq_instr | sw_event_q[`MIC_EV_SOFTWARE_IRQ_INSTR];
   wire ev_return_from_irq_instr = return_from_irq_instr | sw_event_q[`MIC_EV_RETURN_FROM_IRQ_INSTR];
   wire ev_timer = timer_request | sw_event_q[`MIC_EV_TIMER];
   wire ev_serial = serial_request | sw_event_q[`MIC_EV_SERIAL];

   assign request_flags = {serial_request_flag_q, sel_request_flag_q, rise_request_flag_q,
      timer_request_flag_q, level_request_flag_q}; //R13

   // Mask bits follow the order level, timer, rise, selectable, serial
   wire [4:0] qualified = {serial_request_flag_q, sel_request_flag_q, rise_request_flag_q,
      timer_request_flag_q, level_request_flag_q} & ~mask_q[4:0]; //R23

   // Soft request overrides the enable flip-flop
   wire hw_open = ie_q & ~soft_request_ff_q; //R3 R5
   wire [4:0] gated = hw_open ? qualified : 5'h00;
   wire [4:0] grant;
   wire [15:0] vector;

   mic_prio u_prio (
      .req(gated),
      .grant(grant),
      .vector(vector)
   );

   assign irq_pending = |grant;
   // Taken only when core acknowledges; a chain does not hold it off
   wire hw_take = irq_pending & irq_ack & ~ev_software_irq_instr; //R17

   // ==========================================================
   // Chain detection: only a same-group load following a load of that group
   wire is_a = immediate_load_instr & acc_load_instr;
   wire is_b = pair_immediate_load_instr | (immediate_load_instr & ~acc_load_instr);
   wire any_instr = is_a | is_b | other_instr;
   assign exec_suppress = (is_a & acc_chain_flag_q) | (is_b & pair_chain_flag_q); //R14 R15

   assign program_status_word = {psw_alu_flags[7:4], acc_chain_flag_q, pair_chain_flag_q,
      psw_alu_flags[1:0]};

   // ==========================================================
   // Control and flag update
   always @(posedge aclk) begin
      if (!aresetn) begin
         ie_q <= 1'b0; //R4
         soft_request_ff_q <= 1'b0;
         level_request_flag_q <= 1'b0;
         rise_request_flag_q <= 1'b0;
         sel_request_flag_q <= 1'b0;
         timer_request_flag_q <= 1'b0;
         serial_request_flag_q <= 1'b0;
         acc_chain_flag_q <= 1'b0;
         pair_chain_flag_q <= 1'b0;
         accept_q <= 1'b0;
         vector_q <= 16'h0000;
         saved_pc_q <= 16'h0000;
         saved_psw_q <= `MIC_PSW_RST;
         resume_pc_q <= 16'h0000;
         psw_base_q <= `MIC_PSW_RST;
      end else begin
         accept_q <= 1'b0;
         if (ev_ei) begin
            ie_q <= 1'b1; //R2
         end
         if (ev_di) begin
            ie_q <= 1'b0; //R2
         end
         if (hw_take) begin
            ie_q <= 1'b0; //R7
         end
         level_request_flag_q <= pin_s2_q[0]; //R20
         // New edge wins over the clear from acceptance
         rise_request_flag_q <= (rise_request_flag_q & ~(hw_take & grant[2])) | rise_edge; //R10 R21
         sel_request_flag_q <= (sel_request_flag_q & ~(hw_take & grant[3])) | sel_edge; //R10
         timer_request_flag_q <= (timer_request_flag_q & ~(hw_take & grant[1])) | ev_timer; //R22
         serial_request_flag_q <= (serial_request_flag_q & ~(hw_take & grant[4])) | ev_serial;
         if (ev_return_from_irq_instr) begin
            soft_request_ff_q <= 1'b0; //R6
            acc_chain_flag_q <= restore_psw[`MIC_PSW_L1]; //R24
            pair_chain_flag_q <= restore_psw[`MIC_PSW_L0];
            psw_base_q <= restore_psw;
            resume_pc_q <= restore_pc; //R24
         end else if (any_instr) begin
            acc_chain_flag_q <= is_a; //R16
            pair_chain_flag_q <= is_b; //R16
         end
         if (ev_software_irq_instr) begin
            soft_request_ff_q <= 1'b1; //R5 R12
            accept_q <= 1'b1;
            vector_q <= `MIC_VEC_SOFT; //R11
            saved_pc_q <= program_counter; //R11
            saved_psw_q <= program_status_word;
         end else if (hw_take) begin
            accept_q <= 1'b1;
            vector_q <= vector; //R9
            saved_pc_q <= program_counter; //R8
            saved_psw_q <= program_status_word; //R8 R17
         end
      end
   end

   // ==========================================================
   // AXI4-Lite slave, one write and one read in flight
   reg aw_hold_q;
   reg w_hold_q;
   reg [4:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire aw_ok = aw_hold_q | (s_axi_awvalid & s_axi_awready);
   wire w_ok = w_hold_q | (s_axi_wvalid & s_axi_wready);
   wire [4:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
   wire [3:0] ws = w_hold_q ? wstrb_q : s_axi_wstrb;
   wire do_write = aw_ok & w_ok;

   function known_addr;
      input [4:0] a;
      begin
         known_addr = (a == `MIC_OFF_MASK) || (a == `MIC_OFF_CTRL) || (a == `MIC_OFF_STAT) ||
            (a == `MIC_OFF_EVENT) || (a == `MIC_OFF_ACCEPT);
      end
   endfunction

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 5'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'b00;
         s_axi_rdata <= 32'h00000000;
         mask_q <= `MIC_MASK_RST;
         sw_event_q <= 6'h00;
      end else begin
         sw_event_q <= 6'h00;
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known_addr(wa) ? 2'b00 : 2'b10;
            if (wa == `MIC_OFF_MASK && ws[0]) begin
               mask_q <= {2'b00, wd[5:0]}; //R18
            end
            if (wa == `MIC_OFF_EVENT && ws[0]) begin
               sw_event_q <= wd[5:0];
            end
         end else begin
            if (s_axi_awvalid & s_axi_awready) begin
               aw_hold_q <= 1'b1;
               awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
               w_hold_q <= 1'b1;
               wdata_q <= s_axi_wdata;
               wstrb_q <= s_axi_wstrb;
            end
         end
         if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= known_addr(s_axi_araddr) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
               `MIC_OFF_MASK: s_axi_rdata <= {24'h000000, mask_q};
               `MIC_OFF_CTRL: s_axi_rdata <= {27'h0000000, grant};
               `MIC_OFF_STAT: s_axi_rdata <= {19'h00000, accept_q, acc_chain_flag_q,
                  pair_chain_flag_q, soft_request_ff_q, ie_q, 3'h0, request_flags}; //R13
               `MIC_OFF_ACCEPT: s_axi_rdata <= {vector_q, saved_pc_q};
               default: s_axi_rdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

// file: verification/mic_ctrl_monitor.sv
// Assertion checker for the interrupt control block
`timescale 1ns/10ps
module mic_ctrl_monitor (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Core inputs
   input wire disable_irq_instr,
   input wire software_irq_instr,
   input wire return_from_irq_instr,
   input wire immediate_load_instr,
   input wire acc_load_instr,
   input wire other_instr,
   input wire irq_ack,
   input wire timer_request,
   input wire [15:0] program_counter,
   input wire [15:0] restore_pc,
   // Block outputs
   input wire irq_pending,
   input wire accept_q,
   input wire [15:0] vector_q,
   input wire [15:0] saved_pc_q,
   input wire [15:0] resume_pc_q,
   input wire [7:0] program_status_word,
   input wire exec_suppress,
   input wire [4:0] request_flags
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========
   // Acceptance, return, chaining and reset
   AST_TAKE: assert property (irq_pending && irq_ack && !software_irq_instr |=> accept_q)
      else $error("pending request not taken");
   AST_HOLD: assert property (!irq_pending && !software_irq_instr |=> !accept_q)
      else $error("acceptance without cause");
   AST_HW_OFF: assert property (accept_q && vector_q != 16'h0060 |-> !irq_pending)
      else $error("enable left set after acceptance");
   AST_DI: assert property (disable_irq_instr |=> !irq_pending)
      else $error("disable did not block");
   AST_SOFT: assert property (software_irq_instr |=> accept_q && vector_q == 16'h0060 && !irq_pending)
      else $error("soft interrupt wrong");
   AST_FLAG: assert property (accept_q && vector_q == 16'h0008 && !$past(timer_request)
      |-> !request_flags[1])
      else $error("timer flag not cleared");
   AST_PC: assert property (accept_q |-> saved_pc_q == $past(program_counter))
      else $error("saved counter wrong");
   AST_RET: assert property (return_from_irq_instr |=> resume_pc_q == $past(restore_pc))
      else $error("resume counter wrong");
   AST_CHAIN: assert property (immediate_load_instr && acc_load_instr ##1
      immediate_load_instr && acc_load_instr |-> exec_suppress)
      else $error("chained load executed");
   AST_CLR: assert property (other_instr |=> program_status_word[3:2] == 2'b00)
      else $error("chain flags kept");
   AST_RST: assert property ($rose(aresetn) |-> !irq_pending && !accept_q)
      else $error("enabled after reset");
endmodule
bind mic_ctrl mic_ctrl_monitor mic_ctrl_monitor_i (.*);

// file: verification/mic_core_model.sv
// Behavioural model of the instruction core beside the interrupt block
`timescale 1ns/10ps
module mic_core_model (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // From the block
   input wire accept_q,
   input wire [15:0] saved_pc_q,
   input wire [7:0] saved_psw_q,
   // Bench control
   input wire ack_en,
   // To the block
   output logic irq_ack,
   output logic [15:0] program_counter,
   output logic [7:0] psw_alu_flags,
   output logic [15:0] restore_pc,
   output logic [7:0] restore_psw
);
   // One-deep stack: the bench never nests interrupts
   always @(posedge aclk) begin
      if (!aresetn) begin
         program_counter <= 16'h0100;
         restore_pc <= 16'h0000;
         restore_psw <= 8'h00;
      end else begin
         program_counter <= program_counter + 16'h0001;
         if (accept_q) begin
            restore_pc <= saved_pc_q;
            restore_psw <= saved_psw_q;
         end
      end
   end
   assign irq_ack = ack_en;
   assign psw_alu_flags = 8'h41;
endmodule

// file: verification/mic_ctrl_tb.sv
// Self-checking bench for the interrupt control block
`timescale 1ns/10ps
module mic_ctrl_tb;
   // ==========
   // Wiring
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ack_en = 1'b1;
   logic ext_level_request = 1'b0, ext_rise_request = 1'b0;
   logic ext_selectable_edge_request = 1'b0;
   logic [9:0] ins = 10'h000;
   wire enable_irq_instr = ins[0], disable_irq_instr = ins[1];
   wire software_irq_instr = ins[2], return_from_irq_instr = ins[3];
   wire immediate_load_instr = ins[4], acc_load_instr = ins[5];
   wire pair_immediate_load_instr = ins[6], other_instr = ins[7];
   wire timer_request = ins[8], serial_request = ins[9];
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire irq_ack, irq_pending, accept_q, exec_suppress;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] vector_q, saved_pc_q, resume_pc_q, program_counter, restore_pc;
   wire [7:0] saved_psw_q, program_status_word, psw_alu_flags, restore_psw;
   wire [4:0] request_flags;
   logic [31:0] rdat;
   logic [1:0] rsp;
   logic [15:0] last_v;
   logic last_l1;
   int acc_n = 0;
   int err_count = 0;
   int compares = 0;
   logic [9:0] steps [6] = '{10'h030, 10'h030, 10'h030, 10'h010, 10'h040, 10'h080};
   logic [5:0] sup = 6'b010110;

   mic_ctrl mic_ctrl_i (.*);
   mic_core_model mic_core_model_i (.*);

   always #2.5 aclk = ~aclk;
   // Acceptance is a one-cycle pulse, so log it
   always @(posedge aclk) begin
      if (accept_q) begin
         acc_n <= acc_n + 1;
         last_v <= vector_q;
         last_l1 <= saved_psw_q[3];
      end
   end

   // ==========
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Each channel is judged at the rising edge where its handshake completes
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [2:0] left;
      left = 3'b111;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (left != 3'b000) begin
         @(posedge aclk);
         if (left[2] && s_axi_awready) begin
            left[2] = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (left[1] && s_axi_wready) begin
            left[1] = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
         if (left[0] && s_axi_bvalid) begin
            left[0] = 1'b0;
            s_axi_bready <= 1'b0;
         end
      end
   endtask
   task automatic rd(input logic [4:0] a);
      logic [1:0] left;
      left = 2'b11;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (left != 2'b00) begin
         @(posedge aclk);
         if (left[1] && s_axi_arready) begin
            left[1] = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         if (left[0] && s_axi_rvalid) begin
            left[0] = 1'b0;
            rdat = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
   endtask
   task automatic go(input logic [9:0] v);
      @(posedge aclk);
      ins <= v;
   endtask
   task automatic wait_acc(input int n0, input logic [15:0] v);
      for (int n = 0; n < 40 && acc_n == n0; n++)
         @(posedge aclk);
      chk(acc_n, n0 + 1);
      chk(last_v, v);
   endtask

   // ==========
   // Scenarios
   task automatic t_regs;
      rd(5'h08);
      chk(rdat, 32'h0);
      wr(5'h00, 32'hff);
      rd(5'h00);
      chk(rdat, 32'h3f);
      rd(5'h14);
      chk(rsp, 2'b10);
      chk(rdat, 32'h0);
   endtask
   task automatic t_prio;
      wr(5'h00, 32'h20);
      ext_level_request <= 1'b1;
      ext_rise_request <= 1'b1;
      ext_selectable_edge_request <= 1'b1;
      go(10'h300);
      go(10'h000);
      repeat (6) @(posedge aclk);
      rd(5'h08);
      chk(rdat, 32'h1f);
      for (int i = 0; i < 5; i++) begin
         int n0;
         n0 = acc_n;
         wr(5'h0c, 32'h1);
         wait_acc(n0, 16'h4 << i);
         ext_level_request <= 1'b0;
         repeat (4) @(posedge aclk);
         chk(request_flags, (32'h1f << (i + 1)) & 32'h1f);
      end
   endtask
   task automatic t_mask;
      int n0;
      n0 = acc_n;
      wr(5'h00, 32'h22);
      go(10'h100);
      go(10'h001);
      go(10'h000);
      repeat (6) @(posedge aclk);
      chk(acc_n, n0);
      chk(request_flags, 32'h02);
      go(10'h002);
      go(10'h000);
      wr(5'h00, 32'h00);
      repeat (6) @(posedge aclk);
      chk(acc_n, n0);
      ext_selectable_edge_request <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(request_flags, 32'h0a);
      go(10'h001);
      go(10'h000);
      wait_acc(n0, 16'h0008);
      go(10'h001);
      go(10'h000);
      wait_acc(n0 + 1, 16'h0020);
   endtask
   task automatic t_chain;
      int n0;
      for (int i = 0; i < 6; i++) begin
         go(steps[i]);
         #1;
         chk(exec_suppress, sup[i]);
      end
      chk(program_status_word[3:2], 2'b01);
      n0 = acc_n;
      go(10'h030);
      go(10'h030);
      go(10'h004);
      go(10'h000);
      wait_acc(n0, 16'h0060);
      chk(last_l1, 1'b1);
      go(10'h100);
      go(10'h001);
      go(10'h080);
      go(10'h000);
      repeat (6) @(posedge aclk);
      chk(acc_n, n0 + 1);
      go(10'h008);
      go(10'h000);
      #1;
      chk(program_status_word[3:2], 2'b10);
      wait_acc(n0 + 1, 16'h0008);
   endtask

   task automatic report_and_stop;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_prio;
      t_mask;
      t_chain;
      wr(5'h0c, 32'h1);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(5'h08);
      chk(rdat, 32'h0);
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      report_and_stop;
   end
endmodule
